// ==== core/ufr_pkg.sv ====
package ufr_pkg;

    // register offsets
    localparam logic [7:0] ADDR_PENDING = 8'h00;
    localparam logic [7:0] ADDR_MASK = 8'h01;
    localparam logic [7:0] ADDR_FUNC_ADDR = 8'h02;
    localparam logic [7:0] ADDR_HUB_PID_LO = 8'h15;
    localparam logic [7:0] ADDR_HUB_PID_HI = 8'h16;
    localparam logic [7:0] ADDR_HUB_VID_LO = 8'h17;
    localparam logic [7:0] ADDR_HUB_VID_HI = 8'h18;

    // per endpoint: index 0 ctrl_in, 1 ctrl_out, 2 intr_in
    localparam int EP_CTRL_IN = 0;
    localparam int EP_CTRL_OUT = 1;
    localparam int EP_INTR_IN = 2;
    localparam int NUM_EP = 3;
    localparam logic [2:0][7:0] ADDR_FIFO = {8'h10, 8'h09, 8'h04};
    localparam logic [2:0][7:0] ADDR_BYTE_COUNT = {8'h11, 8'h0A, 8'h05};
    localparam logic [2:0][7:0] ADDR_CTRL = {8'h12, 8'h0B, 8'h06};
    localparam logic [2:0][7:0] ADDR_STAT = {8'h13, 8'h0C, 8'h07};
    localparam logic [2:0][7:0] ADDR_FLAGS = {8'h14, 8'h0D, 8'h08};
    localparam logic [2:0][7:0] CTRL_WMASK = {8'hCB, 8'h8B, 8'h8B};

    // field positions
    localparam int BIT_SUSPEND = 4;
    localparam int BIT_FUNC_RESET = 3;
    localparam int CTL_ENABLE = 0;
    localparam int CTL_FIFO_EN = 1;
    localparam int FF_OVERRUN = 0;
    localparam int FF_UNDERRUN = 1;
    localparam int STAT_ACK = 0;

    // widths and reset values
    localparam int EVT_W = 5;
    localparam int BYTE_COUNT_W = 4;
    localparam int FADDR_W = 7;
    localparam logic [EVT_W-1:0] MASK_RESET = 5'h00;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [3:0] LAST_BIT = 4'h7;

    typedef enum logic [2:0] {
        I2C_IDLE = 3'b000,
        I2C_DEV = 3'b001,
        I2C_ACK_DEV = 3'b010,
        I2C_REG = 3'b011,
        I2C_WR = 3'b100,
        I2C_ACK_WR = 3'b101,
        I2C_RD = 3'b110,
        I2C_RD_ACK = 3'b111
    } ufr_i2c_st_t;

    // endpoint condition inputs from the transfer engine
    typedef struct packed {
        logic [2:0] ack_set;
        logic [2:0] overrun_set;
        logic [2:0] underrun_set;
        logic [2:0] fifo_empty;
        logic [2:0] fifo_full;
        logic [2:0][6:0] status_hi;
    } ufr_ep_in_t;

    typedef struct packed {
        logic [2:0] scl_sync;
        logic [2:0] sda_sync;
        logic scl_q;
        logic sda_q;
        ufr_i2c_st_t st;
        logic [3:0] cnt;
        logic [7:0] sh;
        logic [7:0] ptr;
        logic rw;
        logic nack;
        logic sda_oe;
        logic suspend_flag;
        logic function_reset_flag;
        logic suspend_req;
        logic reset_req;
        logic [2:0] evt;
        logic [EVT_W-1:0] mask;
        logic [FADDR_W-1:0] faddr;
        logic [2:0][BYTE_COUNT_W-1:0] byte_count;
        logic [2:0][7:0] ctrl;
        logic [2:0] ack;
        logic [2:0] overrun;
        logic [2:0] underrun;
        logic [15:0] hub_pid;
        logic [15:0] hub_vid;
        logic [1:0] tx_push;
        logic [7:0] tx_data;
        logic rx_pop;
        logic suspend_go;
        logic reset_go;
    } ufr_state_t;

endpackage

// ==== core/ufr_regs.sv ====
`timescale 1ns/10ps
// Function
// - irq stays high while any unmasked pending flag is set
// - masked sources still set their pending flag, only irq is held off
// - pending at 00h and mask at 01h share layout, sources in bits 4:0
// - suspend flag bit 4 sets on global or selective suspend detect
// - suspend entry waits until the suspend flag is cleared
// - suspend and function-reset flags clear on write 1, 0 keeps them
// - function-reset flag bit 3 sets when host starts port reset
// - function reset runs only after the function-reset flag is cleared
// - function reset keeps endpoint 0 rx/tx enables, reset flag and all mask bits; intr_in control clears
// - intr_in event bit 2 follows ack, overrun or underrun of endpoint 1
// - ctrl_out event bit 1 follows endpoint 0 receive ack/overrun/underrun
// - ctrl_in event bit 0 follows endpoint 0 transmit ack/overrun/underrun
// - endpoint event bits are read-only, clear with their cause
// - all five pending flags clear at power-on reset
// - 4-bit byte count registers at 05h, 0Ah and 11h
// - fifo flag registers at 08h, 0Dh, 14h: empty, full, underrun, overrun
// - 16-bit hub product and vendor codes at 15h to 18h, low byte first
// - registers take one byte per access, fifo ports stream bytes
// - transmit fifo ports are write-only, receive fifo port read-only
module ufr_regs #(
    parameter logic [6:0] DEV_ADDR = 7'h2A,
    // arbitrary neutral identity values
    parameter logic [15:0] HUB_PID_INIT = 16'h0001,
    parameter logic [15:0] HUB_VID_INIT = 16'h0001
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // two-wire serial port
    input wire logic i_scl,
    input wire logic i_sda,
    output logic o_sda,
    output logic o_sda_oe,
    // hub and transfer engine conditions
    input wire logic i_suspend_det,
    input wire logic i_port_reset,
    input wire logic i_func_enabled,
    input wire ufr_pkg::ufr_ep_in_t i_ep,
    // fifo data paths
    output logic [1:0] o_tx_push,
    output logic [7:0] o_tx_data,
    output logic o_rx_pop,
    input wire logic [7:0] i_rx_data,
    // function control outputs
    output logic o_irq,
    output logic o_suspend_go,
    output logic o_function_reset,
    output logic [ufr_pkg::FADDR_W-1:0] o_func_addr,
    output logic [2:0][7:0] o_ep_ctrl,
    output logic [2:0][ufr_pkg::BYTE_COUNT_W-1:0] o_byte_count,
    output logic [15:0] o_hub_pid,
    output logic [15:0] o_hub_vid
);

    // reserved and ten-bit prefixes cannot be served
    if (DEV_ADDR[6:3] == 4'h0 || DEV_ADDR[6:3] == 4'hF) begin : g_chk
        $error("device address lies in a reserved range");
    end

    ufr_pkg::ufr_state_t r;
    ufr_pkg::ufr_state_t n;
    logic [1:0] rst_ff;
    logic rst_n_s;
    logic scl_rise;
    logic scl_fall;
    logic start_c;
    logic stop_c;
    logic do_load;
    logic wr_en;
    logic [7:0] wd;
    logic [7:0] rd;
    logic fr_go;
    logic susp_clr;
    logic function_reset_flag_clr;
    logic [2:0] ack_clr;
    logic [2:0] ovr_clr;
    logic [2:0] und_clr;

    function automatic logic [7:0] rd_byte(input ufr_pkg::ufr_state_t s,
                                           input ufr_pkg::ufr_ep_in_t e,
                                           input logic [7:0] rx,
                                           input logic fen);
        logic [7:0] v;
        v = 8'h00;
        unique case (s.ptr)
            ufr_pkg::ADDR_PENDING:
                v = {3'h0, s.suspend_flag, s.function_reset_flag, s.evt};
            ufr_pkg::ADDR_MASK: v = {3'h0, s.mask};
            ufr_pkg::ADDR_FUNC_ADDR: v = {fen, s.faddr};
            ufr_pkg::ADDR_HUB_PID_LO: v = s.hub_pid[7:0];
            ufr_pkg::ADDR_HUB_PID_HI: v = s.hub_pid[15:8];
            ufr_pkg::ADDR_HUB_VID_LO: v = s.hub_vid[7:0];
            ufr_pkg::ADDR_HUB_VID_HI: v = s.hub_vid[15:8];
            default: v = 8'h00;
        endcase
        // transmit fifo ports read as zero
        if (s.ptr == ufr_pkg::ADDR_FIFO[ufr_pkg::EP_CTRL_OUT]) begin
            v = rx;
        end
        for (int k = 0; k < ufr_pkg::NUM_EP; k++) begin
            if (s.ptr == ufr_pkg::ADDR_BYTE_COUNT[k]) begin
                v = {4'h0, s.byte_count[k]};
            end
            if (s.ptr == ufr_pkg::ADDR_CTRL[k]) begin
                v = s.ctrl[k];
            end
            if (s.ptr == ufr_pkg::ADDR_STAT[k]) begin
                v = {e.status_hi[k], s.ack[k]};
            end
            if (s.ptr == ufr_pkg::ADDR_FLAGS[k]) begin
                v = {4'h0, e.fifo_empty[k], e.fifo_full[k],
                     s.underrun[k], s.overrun[k]};
            end
        end
        return v;
    endfunction

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rst_ff <= 2'h0;
        end else begin
            rst_ff <= {rst_ff[0], 1'b1};
        end
    end
    assign rst_n_s = rst_ff[1];

    always_comb begin
        n = r;
        n.tx_push = 2'h0;
        n.rx_pop = 1'b0;
        n.suspend_go = 1'b0;
        n.reset_go = 1'b0;
        do_load = 1'b0;
        wr_en = 1'b0;
        wd = r.sh;
        rd = 8'h00;
        susp_clr = 1'b0;
        function_reset_flag_clr = 1'b0;
        ack_clr = 3'h0;
        ovr_clr = 3'h0;
        und_clr = 3'h0;
        fr_go = r.reset_req && !r.function_reset_flag;

        // pin filtering: second and third stage must agree
        n.scl_sync = {r.scl_sync[1:0], i_scl};
        n.sda_sync = {r.sda_sync[1:0], i_sda};
        if (r.scl_sync[1] == r.scl_sync[2]) begin
            n.scl_q = r.scl_sync[2];
        end
        if (r.sda_sync[1] == r.sda_sync[2]) begin
            n.sda_q = r.sda_sync[2];
        end
        scl_rise = n.scl_q && !r.scl_q;
        scl_fall = !n.scl_q && r.scl_q;
        start_c = r.scl_q && n.scl_q && r.sda_q && !n.sda_q;
        stop_c = r.scl_q && n.scl_q && !r.sda_q && n.sda_q;

        // serial engine; pointer never advances, so register accesses
        // stay single byte while fifo ports stream
        if (start_c) begin
            n.st = ufr_pkg::I2C_DEV;
            n.cnt = 4'h0;
            n.sda_oe = 1'b0;
        end else if (stop_c) begin
            n.st = ufr_pkg::I2C_IDLE;
            n.sda_oe = 1'b0;
        end else if (scl_rise) begin
            if (r.st == ufr_pkg::I2C_RD_ACK) begin
                n.nack = n.sda_q;
            end else if (r.st == ufr_pkg::I2C_DEV
                         || r.st == ufr_pkg::I2C_REG
                         || r.st == ufr_pkg::I2C_WR) begin
                n.sh = {r.sh[6:0], n.sda_q};
                n.cnt = r.cnt + 4'h1;
            end
        end else if (scl_fall) begin
            unique case (r.st)
                ufr_pkg::I2C_IDLE: begin
                end
                ufr_pkg::I2C_DEV: begin
                    if (r.cnt == ufr_pkg::BITS_PER_BYTE) begin
                        if (r.sh[7:1] == DEV_ADDR) begin
                            n.sda_oe = 1'b1;
                            n.rw = r.sh[0];
                            n.st = ufr_pkg::I2C_ACK_DEV;
                        end else begin
                            n.st = ufr_pkg::I2C_IDLE;
                        end
                    end
                end
                ufr_pkg::I2C_ACK_DEV: begin
                    n.cnt = 4'h0;
                    if (r.rw) begin
                        do_load = 1'b1;
                    end else begin
                        n.sda_oe = 1'b0;
                        n.st = ufr_pkg::I2C_REG;
                    end
                end
                ufr_pkg::I2C_REG: begin
                    if (r.cnt == ufr_pkg::BITS_PER_BYTE) begin
                        n.ptr = r.sh;
                        n.sda_oe = 1'b1;
                        n.st = ufr_pkg::I2C_ACK_WR;
                    end
                end
                ufr_pkg::I2C_WR: begin
                    if (r.cnt == ufr_pkg::BITS_PER_BYTE) begin
                        wr_en = 1'b1;
                        n.sda_oe = 1'b1;
                        n.st = ufr_pkg::I2C_ACK_WR;
                    end
                end
                ufr_pkg::I2C_ACK_WR: begin
                    n.sda_oe = 1'b0;
                    n.cnt = 4'h0;
                    n.st = ufr_pkg::I2C_WR;
                end
                ufr_pkg::I2C_RD: begin
                    if (r.cnt == ufr_pkg::LAST_BIT) begin
                        n.sda_oe = 1'b0;
                        n.st = ufr_pkg::I2C_RD_ACK;
                    end else begin
                        n.sh = {r.sh[6:0], 1'b0};
                        n.sda_oe = !r.sh[6];
                        n.cnt = r.cnt + 4'h1;
                    end
                end
                ufr_pkg::I2C_RD_ACK: begin
                    if (r.nack) begin
                        n.st = ufr_pkg::I2C_IDLE;
                    end else begin
                        n.cnt = 4'h0;
                        do_load = 1'b1;
                    end
                end
            endcase
        end

        if (do_load) begin
            rd = rd_byte(r, i_ep, i_rx_data, i_func_enabled);
            n.sh = rd;
            n.sda_oe = !rd[7];
            n.st = ufr_pkg::I2C_RD;
            n.rx_pop = (r.ptr == ufr_pkg::ADDR_FIFO[ufr_pkg::EP_CTRL_OUT]);
        end

        // function reset wipes function state but not the serial engine
        if (fr_go) begin
            n.reset_go = 1'b1;
            n.faddr = '0;
            n.byte_count = '0;
            n.ack = 3'h0;
            n.overrun = 3'h0;
            n.underrun = 3'h0;
            n.suspend_flag = 1'b0;
            n.suspend_req = 1'b0;
            n.tx_data = 8'h00;
            n.ctrl[ufr_pkg::EP_INTR_IN] = 8'h00;
            for (int k = 0; k < 2; k++) begin
                n.ctrl[k] = r.ctrl[k] & 8'h01;
            end
        end

        if (wr_en) begin
            unique case (r.ptr)
                ufr_pkg::ADDR_PENDING: begin
                    susp_clr = wd[ufr_pkg::BIT_SUSPEND];
                    function_reset_flag_clr = wd[ufr_pkg::BIT_FUNC_RESET];
                end
                ufr_pkg::ADDR_MASK: n.mask = wd[ufr_pkg::EVT_W-1:0];
                ufr_pkg::ADDR_FUNC_ADDR: n.faddr = wd[6:0];
                ufr_pkg::ADDR_HUB_PID_LO: n.hub_pid[7:0] = wd;
                ufr_pkg::ADDR_HUB_PID_HI: n.hub_pid[15:8] = wd;
                ufr_pkg::ADDR_HUB_VID_LO: n.hub_vid[7:0] = wd;
                ufr_pkg::ADDR_HUB_VID_HI: n.hub_vid[15:8] = wd;
                default: begin
                end
            endcase
            for (int k = 0; k < ufr_pkg::NUM_EP; k++) begin
                if (r.ptr == ufr_pkg::ADDR_FIFO[k] && k != 1) begin
                    n.tx_push[k/2] = 1'b1;
                    n.tx_data = wd;
                end
                if (r.ptr == ufr_pkg::ADDR_BYTE_COUNT[k]) begin
                    n.byte_count[k] = wd[ufr_pkg::BYTE_COUNT_W-1:0];
                    n.ctrl[k][ufr_pkg::CTL_FIFO_EN] = 1'b1;
                end
                if (r.ptr == ufr_pkg::ADDR_CTRL[k]) begin
                    n.ctrl[k] = wd & ufr_pkg::CTRL_WMASK[k];
                end
                if (r.ptr == ufr_pkg::ADDR_STAT[k]) begin
                    ack_clr[k] = wd[ufr_pkg::STAT_ACK];
                end
                if (r.ptr == ufr_pkg::ADDR_FLAGS[k]) begin
                    ovr_clr[k] = wd[ufr_pkg::FF_OVERRUN];
                    und_clr[k] = wd[ufr_pkg::FF_UNDERRUN];
                end
            end
        end

        // sticky causes: set beats clear
        n.ack = (n.ack & ~ack_clr) | i_ep.ack_set;
        n.overrun = (n.overrun & ~ovr_clr) | i_ep.overrun_set;
        n.underrun = (n.underrun & ~und_clr) | i_ep.underrun_set;
        // event bits follow their causes, writes cannot touch them
        n.evt = n.ack | n.overrun
                | n.underrun;

        n.suspend_flag = (n.suspend_flag & ~susp_clr)
                         | i_suspend_det;
        n.function_reset_flag = (r.function_reset_flag & ~function_reset_flag_clr)
                                | i_port_reset;
        // low-power entry held until firmware acknowledges
        if (r.suspend_req && !r.suspend_flag && !fr_go) begin
            n.suspend_go = 1'b1;
            n.suspend_req = 1'b0;
        end
        if (fr_go) begin
            n.reset_req = 1'b0;
        end
        if (i_suspend_det) begin
            n.suspend_req = 1'b1;
        end
        if (i_port_reset) begin
            n.reset_req = 1'b1;
        end
    end

    always_ff @(posedge i_clk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            r <= '0;
            r.scl_sync <= 3'h7;
            r.sda_sync <= 3'h7;
            r.scl_q <= 1'b1;
            r.sda_q <= 1'b1;
            r.mask <= ufr_pkg::MASK_RESET;
            r.hub_pid <= HUB_PID_INIT;
            r.hub_vid <= HUB_VID_INIT;
        end else begin
            r <= n;
        end
    end

    // open drain: only ever pulls low
    assign o_sda = 1'b0;
    assign o_sda_oe = r.sda_oe;
    assign o_irq = |({r.suspend_flag, r.function_reset_flag, r.evt}
                     & ~r.mask);
    assign o_suspend_go = r.suspend_go;
    assign o_function_reset = r.reset_go;
    assign o_tx_push = r.tx_push;
    assign o_tx_data = r.tx_data;
    assign o_rx_pop = r.rx_pop;
    assign o_func_addr = r.faddr;
    assign o_ep_ctrl = r.ctrl;
    assign o_byte_count = r.byte_count;
    assign o_hub_pid = r.hub_pid;
    assign o_hub_vid = r.hub_vid;

endmodule

// ==== verif/ufr_regs_properties.sv ====
`timescale 1ns/10ps
module ufr_regs_properties (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // watched inputs
    input wire logic i_scl,
    input wire logic i_suspend_det,
    input wire logic i_port_reset,
    input wire ufr_pkg::ufr_ep_in_t i_ep,
    // watched outputs
    input wire logic o_sda_oe,
    input wire logic [1:0] o_tx_push,
    input wire logic o_irq,
    input wire logic o_suspend_go,
    input wire logic o_function_reset,
    input wire logic [ufr_pkg::FADDR_W-1:0] o_func_addr,
    input wire logic [2:0][7:0] o_ep_ctrl,
    input wire logic [2:0][ufr_pkg::BYTE_COUNT_W-1:0] o_byte_count,
    input wire logic [15:0] o_hub_pid
);
    logic ep_any;
    assign ep_any = |(i_ep.ack_set | i_ep.overrun_set | i_ep.underrun_set);

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rst_n);

    // writes land while scl is low, so clears and go pulses do too
    sequence s_scl_low;
        !i_scl;
    endsequence

    // ep0 enables survive a function reset
    sequence s_func_cleared;
        o_func_addr == 7'h00 && o_byte_count == '0 && o_ep_ctrl[2] == 8'h00
            && o_ep_ctrl[1][7:1] == 7'h00 && o_ep_ctrl[0][7:1] == 7'h00;
    endsequence

    AST_OE_SCL_LOW: assert property (
        $changed(o_sda_oe) |-> s_scl_low)
        else $error("data drive changed while serial clock high");
    AST_IRQ_FALL: assert property ($fell(o_irq) |-> s_scl_low)
        else $error("irq dropped without a register write");
    AST_IRQ_RISE: assert property ($rose(o_irq) |-> !i_scl
        || $past(i_suspend_det) || $past(i_port_reset)
        || $past(ep_any))
        else $error("irq rose without a cause");
    AST_SUSP_GO: assert property (
        o_suspend_go |-> s_scl_low ##1 !o_suspend_go)
        else $error("suspend go not a single pulse after a clear");
    AST_RST_GO: assert property (
        o_function_reset |-> s_scl_low ##1 !o_function_reset)
        else $error("function reset not a single pulse after a clear");
    AST_RST_CLEARS: assert property (
        o_function_reset |=> s_func_cleared)
        else $error("function reset left state behind");
    AST_HUB_KEPT: assert property (
        o_function_reset |=> $stable(o_hub_pid))
        else $error("hub product code changed by function reset");
    AST_PUSH_PULSE: assert property (
        |o_tx_push |-> $onehot(o_tx_push) ##1 o_tx_push == 2'b00)
        else $error("fifo push not a single one-hot pulse");
endmodule

// ==== verif/ufr_mcu_model.sv ====
`timescale 1ns/10ps
module ufr_mcu_model #(
    parameter logic [6:0] DEV = 7'h2A,
    parameter int HALF = 10
) (
    // clock
    input wire logic i_clk,
    // serial pins
    input wire logic i_dev_oe,
    output logic o_scl,
    output logic o_sda
);
    logic drv = 1'b1;
    logic scl = 1'b1;
    int nack_cnt = 0;
    // open drain with pull-up: any party pulling low wins
    assign o_sda = drv & ~i_dev_oe;
    assign o_scl = scl;

    task automatic tick();
        repeat (HALF) @(negedge i_clk);
    endtask

    // also a repeated start when entered with scl low
    task automatic start();
        drv = 1'b1;
        tick();
        scl = 1'b1;
        tick();
        drv = 1'b0;
        tick();
        scl = 1'b0;
    endtask

    task automatic stop();
        drv = 1'b0;
        tick();
        scl = 1'b1;
        tick();
        drv = 1'b1;
        tick();
    endtask

    // ninth bit is the acknowledge slot
    task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
        for (int i = 8; i >= 0; i--) begin
            drv = tx[i];
            tick();
            scl = 1'b1;
            tick();
            rx[i] = o_sda;
            scl = 1'b0;
            // data moves well after the filtered scl fall, never with it
            repeat (4) @(negedge i_clk);
        end
    endtask

    task automatic send(input logic [7:0] b);
        logic [8:0] r;
        xfer({b, 1'b1}, r);
        if (r[0] !== 1'b0) nack_cnt++;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        start();
        send({DEV, 1'b0});
        send(a);
        send(d);
        stop();
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        logic [8:0] r;
        start();
        send({DEV, 1'b0});
        send(a);
        start();
        send({DEV, 1'b1});
        xfer(9'h1FF, r);
        d = r[8:1];
        stop();
    endtask
endmodule

// ==== verif/ufr_regs_tb.sv ====
`timescale 1ns/10ps
`define CHK(act, exp) \
    begin \
        samples_checked++; \
        if ((act) !== (exp)) begin \
            error_cnt++; \
            $display("MISMATCH t=%0t got=%0h exp=%0h", $time, act, exp); \
        end \
    end
module ufr_regs_tb;
    localparam logic [15:0] PID = 16'h1234; // arbitrary
    localparam logic [15:0] VID = 16'h5678; // arbitrary
    logic clk = 1'b0;
    logic rst_n, suspend_det, port_reset, func_enabled;
    ufr_pkg::ufr_ep_in_t ep;
    logic [7:0] rx_data, tx_data, last_tx, tx;
    wire scl;
    wire sda;
    logic sda_oe, rx_pop, irq, sus_go, function_reset_flag_go;
    logic [1:0] tx_push;
    logic [6:0] faddr;
    logic [2:0][7:0] ep_ctrl;
    logic [2:0][3:0] byte_count;
    logic [15:0] pid, vid;
    logic [3:0] bc;
    logic [8:0] r;
    int error_cnt = 0, samples_checked = 0, cyc = 0, kind;
    int push_cnt = 0, pop_cnt = 0, sus_cnt = 0, function_reset_flag_cnt = 0;

    initial forever #10 clk = ~clk;

    ufr_regs #(.HUB_PID_INIT(PID), .HUB_VID_INIT(VID)) uut (
        .i_clk(clk), .i_rst_n(rst_n), .i_scl(scl), .i_sda(sda),
        .o_sda(), .o_sda_oe(sda_oe), .i_suspend_det(suspend_det),
        .i_port_reset(port_reset), .i_func_enabled(func_enabled),
        .i_ep(ep), .o_tx_push(tx_push), .o_tx_data(tx_data),
        .o_rx_pop(rx_pop), .i_rx_data(rx_data), .o_irq(irq),
        .o_suspend_go(sus_go), .o_function_reset(function_reset_flag_go),
        .o_func_addr(faddr), .o_ep_ctrl(ep_ctrl), .o_byte_count(byte_count),
        .o_hub_pid(pid), .o_hub_vid(vid));

    ufr_mcu_model mcu (.i_clk(clk), .i_dev_oe(sda_oe), .o_scl(scl),
        .o_sda(sda));

    task automatic end_sim();
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // a run of about 43k cycles is expected
    always @(negedge clk) begin
        cyc++;
        if (|tx_push) begin
            push_cnt++;
            last_tx = tx_data;
        end
        if (rx_pop) pop_cnt++;
        if (sus_go) sus_cnt++;
        if (function_reset_flag_go) function_reset_flag_cnt++;
        if (cyc == 80000) begin
            error_cnt++;
            end_sim();
        end
    end

    function automatic logic [7:0] fifo_flags(input int k);
        return {4'h0, ep.fifo_empty[k], ep.fifo_full[k], 2'b00};
    endfunction

    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] v;
        mcu.rd(a, v);
        `CHK(v, e)
    endtask

    task automatic fire(input int k, input int kd);
        @(negedge clk);
        if (k == 4) suspend_det = 1'b1;
        else if (k == 3) port_reset = 1'b1;
        else if (kd == 0) ep.ack_set[k] = 1'b1;
        else if (kd == 1) ep.overrun_set[k] = 1'b1;
        else ep.underrun_set[k] = 1'b1;
        @(negedge clk);
        suspend_det = 1'b0;
        port_reset = 1'b0;
        ep.ack_set = 3'h0;
        ep.overrun_set = 3'h0;
        ep.underrun_set = 3'h0;
        repeat (3) @(negedge clk);
    endtask

    initial begin
        {rst_n, suspend_det, port_reset, func_enabled} = 4'h0;
        ep = '0;
        rx_data = 8'h00;
        kind = $urandom(88);
        repeat (16) @(negedge clk);
        rst_n = 1'b1;
        repeat (4) @(negedge clk);
        func_enabled = 1'($urandom);
        rx_data = 8'($urandom);
        rchk(ufr_pkg::ADDR_PENDING, 8'h00);
        rchk(ufr_pkg::ADDR_MASK, 8'h00);
        for (int i = 0; i < 4; i++)
            rchk(8'h15 + 8'(i), 8'({VID, PID} >> (8 * i)));
        `CHK({vid, pid}, {VID, PID})
        $display("test reset values done");
        for (int k = 0; k < 3; k++) begin
            kind = $urandom_range(2);
            // mask bit set holds irq off, so only source k is let through
            mcu.wr(ufr_pkg::ADDR_MASK, 8'h1F ^ 8'(1 << k));
            fire(k, kind);
            `CHK(irq, 1'b1)
            mcu.wr(ufr_pkg::ADDR_PENDING, 8'h07);
            rchk(ufr_pkg::ADDR_PENDING, 8'(1 << k));
            mcu.wr(ufr_pkg::ADDR_MASK, 8'h1F);
            `CHK(irq, 1'b0)
            rchk(ufr_pkg::ADDR_PENDING, 8'(1 << k));
            mcu.wr(kind == 0 ? ufr_pkg::ADDR_STAT[k] : ufr_pkg::ADDR_FLAGS[k],
                kind == 2 ? 8'h02 : 8'h01);
            rchk(ufr_pkg::ADDR_PENDING, 8'h00);
        end
        $display("test endpoint events done");
        bc = 4'($urandom_range(15, 1));
        mcu.wr(ufr_pkg::ADDR_CTRL[0], 8'h01);
        mcu.wr(ufr_pkg::ADDR_BYTE_COUNT[0], {4'h0, bc});
        `CHK(byte_count[0], bc)
        mcu.wr(ufr_pkg::ADDR_MASK, 8'h07);
        fire(3, 0);
        `CHK(irq, 1'b1)
        mcu.wr(ufr_pkg::ADDR_PENDING, 8'h00);
        rchk(ufr_pkg::ADDR_PENDING, 8'h08);
        `CHK(function_reset_flag_cnt, 0)
        mcu.wr(ufr_pkg::ADDR_PENDING, 8'h08);
        `CHK(function_reset_flag_cnt, 1)
        `CHK(byte_count[0], 4'h0)
        `CHK(ep_ctrl[0], 8'h01)
        `CHK(faddr, 7'h00)
        rchk(ufr_pkg::ADDR_MASK, 8'h07);
        rchk(ufr_pkg::ADDR_FUNC_ADDR, {func_enabled, 7'h00});
        $display("test function reset done");
        fire(4, 0);
        `CHK(irq, 1'b1)
        rchk(ufr_pkg::ADDR_PENDING, 8'h10);
        `CHK(sus_cnt, 0)
        mcu.wr(ufr_pkg::ADDR_PENDING, 8'h10);
        `CHK(sus_cnt, 1)
        `CHK(irq, 1'b0)
        rchk(ufr_pkg::ADDR_PENDING, 8'h00);
        $display("test suspend done");
        for (int k = 0; k < 3; k++) begin
            bc = 4'($urandom);
            ep.fifo_empty = 3'($urandom);
            ep.fifo_full = ~ep.fifo_empty;
            mcu.wr(ufr_pkg::ADDR_BYTE_COUNT[k], {4'h0, bc});
            rchk(ufr_pkg::ADDR_BYTE_COUNT[k], {4'h0, bc});
            rchk(ufr_pkg::ADDR_FLAGS[k], fifo_flags(k));
        end
        $display("test counts and flags done");
        tx = 8'($urandom);
        mcu.wr(ufr_pkg::ADDR_FIFO[0], tx);
        `CHK(last_tx, tx)
        `CHK(push_cnt, 1)
        rchk(ufr_pkg::ADDR_FIFO[0], 8'h00);
        rchk(ufr_pkg::ADDR_FIFO[1], rx_data);
        `CHK(pop_cnt, 1)
        mcu.start();
        mcu.xfer({7'h2B, 1'b0, 1'b1}, r);
        mcu.stop();
        `CHK(r[0], 1'b1)
        `CHK(mcu.nack_cnt, 0)
        $display("test fifo ports done");
        end_sim();
    end
endmodule

bind ufr_regs ufr_regs_properties chk (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_scl(i_scl),
    .i_suspend_det(i_suspend_det), .i_port_reset(i_port_reset),
    .i_ep(i_ep), .o_sda_oe(o_sda_oe), .o_tx_push(o_tx_push),
    .o_irq(o_irq), .o_suspend_go(o_suspend_go),
    .o_function_reset(o_function_reset), .o_func_addr(o_func_addr),
    .o_ep_ctrl(o_ep_ctrl), .o_byte_count(o_byte_count),
    .o_hub_pid(o_hub_pid));
